// ==== inc/eqca_pkg.sv ====
// Package with constants and types shared by the equalizer coefficient access block.
// Function
// - Control register resets to 0x8080: bypassed, symmetry on.
// - Control bits 5..0 form the six-bit coefficient pointer.
// - Biquad 1 codes: a0 011011, a1 011010, a2 011001, b1 011101, b2 011100.
// - Biquad 2 codes: a0 100000, a1 011111, a2 011110, b1 100010, b2 100001.
// - Biquad 3 codes: a0 100101, a1 100100, a2 100011, b1 100111, b2 100110.
// - Biquad 4 codes: a0 101010, a1 101001, a2 101000, b1 101100, b2 101011.
// - Biquad 5 codes: a0 101111, a1 101110, a2 101101, b1 110001, b2 110000.
// - Biquad 6 codes: a0 110100, a1 110011, a2 110010, b1 110110, b2 110101.
// - Biquad 7 codes: a0 111001, a1 111000, a2 110111, b1 111011, b2 111010.
// - Control bit 6 picks left (0) or right (1) coefficient block.
// - With symmetry bit 7 set, a coefficient write lands in both blocks.
// - Control bit 15 set passes audio unchanged; clear filters it.
// - Data register writes the pointed coefficient; reads return it.
// - Coefficient memory changes only while bypass is set.
// - Coefficients are 16-bit fixed point, bit 15 most significant.
package eqca_pkg;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned AVS_ADDR_W = 12;
  localparam int unsigned AVS_DATA_W = 32;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [AVS_ADDR_W-3:0] IDX_CTRL  = 10'h060;
  localparam logic [AVS_ADDR_W-3:0] IDX_DATA  = 10'h062;
  localparam logic [AVS_ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [AVS_ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'h0};

  localparam logic [15:0] CTRL_RESET = 16'h8080;
  localparam logic [15:0] CTRL_WMASK = 16'h80ff;

  localparam int unsigned N_BIQUAD  = 7;
  localparam int unsigned N_COEF    = 5;
  localparam int unsigned N_LOC     = N_BIQUAD * N_COEF;
  localparam int unsigned COEF_FRAC = 14;
  localparam logic [2:0]  LAST_SEC  = 3'h6;

  // Lowest pointer code of each biquad; its five codes follow in a row.
  localparam logic [5:0] PTR_FIRST = 6'h19;
  localparam logic [5:0] PTR_LAST  = 6'h3b;
  localparam logic [6:0][5:0] PTR_BQ_BASE = {
    6'h37,
    6'h32,
    6'h2d,
    6'h28,
    6'h23,
    6'h1e,
    6'h19
  };

  // Position of each coefficient above its biquad's lowest code.
  localparam int unsigned OFS_A2 = 0;
  localparam int unsigned OFS_A1 = 1;
  localparam int unsigned OFS_A0 = 2;
  localparam int unsigned OFS_B2 = 3;
  localparam int unsigned OFS_B1 = 4;

  typedef struct packed {
    logic       eq_bypass;
    logic [6:0] rsvd;
    logic       coef_symmetry;
    logic       coef_channel_select;
    logic [5:0] coef_pointer;
  } eqca_ctrl_t;

  typedef struct packed {
    logic [DATA_W-1:0] right;
    logic [DATA_W-1:0] left;
  } eqca_sample_t;

  typedef struct packed {
    logic [DATA_W-1:0] x1;
    logic [DATA_W-1:0] x2;
    logic [DATA_W-1:0] y1;
    logic [DATA_W-1:0] y2;
  } eqca_hist_t;

  typedef enum logic [1:0] {
    F_IDLE,
    F_RUN,
    F_OUT
  } eqca_fstate_t;

endpackage : eqca_pkg

// ==== hw/eqca_buf.sv ====
// Small FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module eqca_buf #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         clk_i,        // System clock.
  input  wire logic         rst_n_i,      // Synchronous reset, active low.
  input  wire logic         in_valid_i,   // Source offers a word.
  input  wire logic [W-1:0] in_data_i,    // Word offered.
  output logic              in_ready_o,   // Room for a word.
  output logic              out_valid_o,  // A word is held.
  output logic [W-1:0]      out_data_o,   // Oldest word held.
  input  wire logic         out_ready_i   // Drain takes the word.
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    rdy;
  } buf_st_t;

  buf_st_t s;
  buf_st_t next_s;
  logic    push;
  logic    pop;

  always_comb begin
    next_s = s;
    push   = in_valid_i && s.rdy;
    pop    = (s.cnt != '0) && out_ready_i;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.rdy = (next_s.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s     <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_o  = s.rdy;
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];

endmodule : eqca_buf
`default_nettype wire

// ==== hw/eqca_top.sv ====
// Equalizer coefficient registers, coefficient memory and seven-stage biquad cascade.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module eqca_top (
  input  wire logic                              clk_i,                // 100 MHz clock.
  input  wire logic                              rst_n_i,              // Synchronous reset, active low.
  input  wire logic [eqca_pkg::AVS_ADDR_W-1:0]   avs_address,          // Byte address.
  input  wire logic                              avs_read,             // Read request.
  input  wire logic                              avs_write,            // Write request.
  input  wire logic [eqca_pkg::AVS_DATA_W-1:0]   avs_writedata,        // Write data.
  input  wire logic [3:0]                        avs_byteenable,       // Byte lanes.
  output logic [eqca_pkg::AVS_DATA_W-1:0]        avs_readdata,         // Read data.
  output logic                                   avs_waitrequest,      // Stall request.
  input  wire logic                              in_valid_i,           // Input sample valid.
  input  wire eqca_pkg::eqca_sample_t            in_data_i,            // Input stereo sample.
  output logic                                   in_ready_o,           // Input can take a sample.
  output logic                                   out_valid_o,          // Output sample valid.
  output eqca_pkg::eqca_sample_t                 out_data_o,           // Output stereo sample.
  input  wire logic                              out_ready_i           // Sink takes the sample.
);
  import eqca_pkg::*;

  typedef struct packed {
    eqca_ctrl_t                               ctrl;
    logic [1:0][N_LOC-1:0][DATA_W-1:0]        coef;
    logic [1:0][N_BIQUAD-1:0][$bits(eqca_hist_t)-1:0] hist;
    logic                                     waitreq;
    logic [AVS_DATA_W-1:0]                    rdata;
    eqca_fstate_t                             fst;
    logic [2:0]                               sec;
    logic [1:0][DATA_W-1:0]                   cur;
    logic                                     out_valid;
    eqca_sample_t                             out_data;
  } eqca_st_t;

  eqca_st_t     s;
  eqca_st_t     next_s;
  logic         buf_valid;
  eqca_sample_t buf_data;
  logic         buf_ready;
  logic         out_free;
  logic         ptr_ok;
  logic [5:0]   ptr_idx;
  logic         blk;

  // Two-entry buffer keeps samples safe while the cascade or the sink stalls.
  eqca_buf #(
    .W     ($bits(eqca_sample_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (in_valid_i),
    .in_data_i   (in_data_i),
    .in_ready_o  (in_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (buf_ready)
  );

  // Merges the low two byte lanes of a write into a 16-bit value.
  function automatic logic [15:0] eqca_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : eqca_merge

  // One biquad section in direct form one, coefficients with 14 fraction bits, saturating output.
  function automatic logic [15:0] eqca_biquad(input logic [15:0] x, input eqca_hist_t h,
                                              input logic [N_COEF-1:0][15:0] c);
    logic signed [35:0] acc;
    logic signed [35:0] sh;
    logic [15:0]        y;
    // Factors are widened before the product so no partial product is cut to 16 bits.
    acc = 36'($signed(c[OFS_A0])) * 36'($signed(x))
        + 36'($signed(c[OFS_A1])) * 36'($signed(h.x1))
        + 36'($signed(c[OFS_A2])) * 36'($signed(h.x2))
        - 36'($signed(c[OFS_B1])) * 36'($signed(h.y1))
        - 36'($signed(c[OFS_B2])) * 36'($signed(h.y2));
    sh = acc >>> COEF_FRAC;
    if (sh > 36'sh0_0000_7fff) begin
      y = 16'h7fff;
    end else if (sh < -36'sh0_0000_8000) begin
      y = 16'h8000;
    end else begin
      y = sh[15:0];
    end
    return y;
  endfunction : eqca_biquad

  // Only listed pointer codes reach a memory location; they form one run of 35 codes.
  assign ptr_ok  = (s.ctrl.coef_pointer >= PTR_FIRST) && (s.ctrl.coef_pointer <= PTR_LAST);
  assign ptr_idx = s.ctrl.coef_pointer - PTR_FIRST;
  assign blk     = s.ctrl.coef_channel_select;

  assign out_free  = !s.out_valid || out_ready_i;
  assign buf_ready = (s.fst == F_IDLE) && (!s.ctrl.eq_bypass || out_free);

  always_comb begin
    logic [N_COEF-1:0][15:0] c;
    logic [5:0]              base;
    eqca_hist_t              h;
    logic [15:0]             y;
    logic [15:0]             wv;
    c      = '0;
    base   = '0;
    h      = '0;
    y      = '0;
    wv     = '0;
    next_s = s;

    // Bus slave: one wait cycle, then the access completes while waitrequest is low.
    if (s.waitreq) begin
      if (avs_read || avs_write) begin
        next_s.waitreq = 1'b0;
        next_s.rdata   = '0;
        if (avs_address == ADDR_CTRL) begin
          next_s.rdata[15:0] = s.ctrl;
        end else if (avs_address == ADDR_DATA && ptr_ok) begin
          next_s.rdata[15:0] = s.coef[blk][ptr_idx];
        end
      end
    end else begin
      next_s.waitreq = 1'b1;
      if (avs_write && avs_address == ADDR_CTRL) begin
        next_s.ctrl = eqca_ctrl_t'(eqca_merge(s.ctrl, avs_writedata[15:0], avs_byteenable[1:0]) & CTRL_WMASK);
      end else if (avs_write && avs_address == ADDR_DATA && ptr_ok && s.ctrl.eq_bypass) begin
        wv = eqca_merge(s.coef[blk][ptr_idx], avs_writedata[15:0], avs_byteenable[1:0]);
        next_s.coef[blk][ptr_idx] = wv;
        if (s.ctrl.coef_symmetry) begin
          next_s.coef[~blk][ptr_idx] = wv;
        end
      end
    end

    // Sample path.
    if (s.out_valid && out_ready_i) begin
      next_s.out_valid = 1'b0;
    end
    case (s.fst)
      F_IDLE: begin
        if (buf_valid && buf_ready) begin
          if (s.ctrl.eq_bypass) begin
            next_s.out_data  = buf_data;
            next_s.out_valid = 1'b1;
          end else begin
            next_s.cur[0] = buf_data.left;
            next_s.cur[1] = buf_data.right;
            next_s.sec    = '0;
            next_s.fst    = F_RUN;
          end
        end
      end
      F_RUN: begin
        base = 6'(s.sec) * 6'h5;
        for (int ch = 0; ch < 2; ch++) begin
          for (int k = 0; k < N_COEF; k++) begin
            c[k] = s.coef[ch][base + 6'(k)];
          end
          h = eqca_hist_t'(s.hist[ch][s.sec]);
          y = eqca_biquad(s.cur[ch], h, c);
          next_s.hist[ch][s.sec] = {s.cur[ch], h.x1, y, h.y1};
          next_s.cur[ch] = y;
        end
        if (s.sec == LAST_SEC) begin
          next_s.fst = F_OUT;
        end else begin
          next_s.sec = s.sec + 3'h1;
        end
      end
      F_OUT: begin
        if (out_free) begin
          next_s.out_data.left  = s.cur[0];
          next_s.out_data.right = s.cur[1];
          next_s.out_valid      = 1'b1;
          next_s.fst            = F_IDLE;
        end
      end
      default: begin
        next_s.fst = F_IDLE;
      end
    endcase

    // Filter history starts clean each time the equalizer is enabled.
    if (s.ctrl.eq_bypass && s.fst == F_IDLE) begin
      next_s.hist = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s         <= '0;
      s.ctrl    <= eqca_ctrl_t'(CTRL_RESET);
      s.waitreq <= 1'b1;
      s.fst     <= F_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign out_valid_o     = s.out_valid;
  assign out_data_o      = s.out_data;

endmodule : eqca_top
`default_nettype wire

// ==== dv/eqca_top_monitor.sv ====
// Port checker for the equalizer coefficient access block.
`timescale 1ns/1ps
`default_nettype none
module eqca_monitor (
  input wire logic                              clk_i,            // Clock.
  input wire logic                              rst_n_i,          // Reset, active low.
  input wire logic [eqca_pkg::AVS_ADDR_W-1:0]   avs_address,      // Address.
  input wire logic                              avs_read,         // Read.
  input wire logic                              avs_write,        // Write.
  input wire logic [eqca_pkg::AVS_DATA_W-1:0]   avs_writedata,    // Write data.
  input wire logic [3:0]                        avs_byteenable,   // Lanes.
  input wire logic [eqca_pkg::AVS_DATA_W-1:0]   avs_readdata,     // Read data.
  input wire logic                              avs_waitrequest,  // Stall.
  input wire logic                              in_valid_i,       // In valid.
  input wire eqca_pkg::eqca_sample_t            in_data_i,        // In sample.
  input wire logic                              in_ready_o,       // In ready.
  input wire logic                              out_valid_o,      // Out valid.
  input wire eqca_pkg::eqca_sample_t            out_data_o,       // Out sample.
  input wire logic                              out_ready_i       // Out ready.
);
  import eqca_pkg::*;
  logic byp;
  // Shadow of the bypass bit, taken at the edge where a control write completes.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) byp <= 1'b1;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL && avs_byteenable[1]) byp <= avs_writedata[15];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_wait_pulse_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_no_idle_ack: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_read_upper_zero: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_ctrl_rsvd_zero: assert property (!avs_waitrequest && avs_read && avs_address == ADDR_CTRL
    |-> avs_readdata[14:8] == 7'h0)
    else $error("control reserved bits read nonzero");
  a_read_data_stands: assert property (!$past(avs_read || avs_write) |-> $stable(avs_readdata))
    else $error("read data changed without a request");
  a_out_hold_stall: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("output sample dropped or changed under stall");
  a_bypass_pass: assert property (byp && in_valid_i && in_ready_o && !out_valid_o && !$past(in_valid_i && in_ready_o)
    |-> ##2 out_valid_o && out_data_o == $past(in_data_i, 2))
    else $error("bypassed sample not passed unchanged after two cycles");
endmodule : eqca_monitor
bind eqca_top eqca_monitor i_mon (.clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_valid_i, .in_data_i, .in_ready_o, .out_valid_o,
  .out_data_o, .out_ready_i);
`default_nettype wire

// ==== dv/tb_eqca_top.sv ====
// Self-checking bench for the equalizer coefficient access block.
`timescale 1ns/1ps
`default_nettype none
module tb_eqca_top;
  import eqca_pkg::*;
  logic clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest, in_valid_i, in_ready_o, out_valid_o, out_ready_i;
  logic [AVS_ADDR_W-1:0] avs_address;
  logic [AVS_DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]            avs_byteenable;
  eqca_sample_t          in_data_i, out_data_o;
  eqca_sample_t          exq[$];
  int                    error_cnt, checks_done, stall, filt;
  logic [15:0]           ctrl_m;
  logic [15:0]           mem_m [2][64];

  eqca_top i_dut (.clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .in_valid_i, .in_data_i, .in_ready_o, .out_valid_o, .out_data_o, .out_ready_i);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'($urandom), d};
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge clk_i);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic [5:0]  p;
    logic [15:0] o;
    p = ctrl_m[5:0];
    bus(1'b1, a, d, q);
    o = (a == ADDR_CTRL) ? ctrl_m : mem_m[ctrl_m[6]][p];
    if (avs_byteenable[0]) o[7:0] = d[7:0];
    if (avs_byteenable[1]) o[15:8] = d[15:8];
    if (a == ADDR_CTRL) ctrl_m = o & 16'h80ff;
    else if (a == ADDR_DATA && ctrl_m[15] && p >= 6'h19 && p <= 6'h3b) begin
      mem_m[ctrl_m[6]][p] = o;
      if (ctrl_m[7]) mem_m[!ctrl_m[6]][p] = o;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic [31:0] q, e;
    logic [5:0]  p;
    p = ctrl_m[5:0];
    e = 32'h0;
    if (a == ADDR_CTRL) e = {16'h0, ctrl_m};
    else if (a == ADDR_DATA && p >= 6'h19 && p <= 6'h3b) e = {16'h0, mem_m[ctrl_m[6]][p]};
    bus(1'b0, a, 16'h0, q);
    check(q, e);
  endtask : rd

  // Control word with random reserved bits, which the block must drop.
  function automatic logic [15:0] ctl(input logic b, input logic s, input logic c, input logic [5:0] p);
    return {b, 7'($urandom), s, c, p};
  endfunction : ctl

  function automatic eqca_sample_t model(input eqca_sample_t x);
    model = x;
    if (filt != 0) model.left = 16'($signed(x.left) >>> 1);
  endfunction : model

  task automatic send(input int n);
    repeat (n) begin
      in_valid_i <= 1'b1;
      in_data_i  <= eqca_sample_t'($urandom);
      @(posedge clk_i);
      while (in_ready_o !== 1'b1) @(posedge clk_i);
    end
    in_valid_i <= 1'b0;
  endtask : send

  task automatic drain();
    for (int i = 0; i < 400 && exq.size() > 0; i++) @(posedge clk_i);
    check(exq.size(), 0);
  endtask : drain

  always @(posedge clk_i) begin
    out_ready_i <= (stall == 2) ? 1'b0 : (stall == 1) ? 1'($urandom % 3 != 0) : 1'b1;
    if (rst_n_i && in_valid_i && in_ready_o) exq.push_back(model(in_data_i));
    if (rst_n_i && out_valid_o && out_ready_i) check(out_data_o, (exq.size() > 0) ? exq.pop_front() : 32'hx);
  end

  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h997e));
    {avs_read, avs_write, in_valid_i, out_ready_i, rst_n_i} = 5'h0;
    {avs_address, avs_writedata, in_data_i} = '0;
    avs_byteenable = 4'hf;
    {error_cnt, checks_done, stall, filt} = '0;
    ctrl_m = 16'h8080;
    foreach (mem_m[c, p]) mem_m[c][p] = 16'h0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_CTRL);
    for (int p = 8'h18; p <= 8'h3c; p++) for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'(c), 6'(p)));
      wr(ADDR_DATA, 16'($urandom));
    end
    for (int p = 8'h18; p <= 8'h3c; p++) for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'(c), 6'(p)));
      rd(ADDR_CTRL);
      rd(ADDR_DATA);
    end
    wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 6'h2a));
    wr(ADDR_DATA, 16'($urandom));
    wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b1, 6'h2a));
    rd(ADDR_DATA);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 6'h1b));
    wr(ADDR_DATA, 16'($urandom));
    rd(ADDR_DATA);
    rd(12'h000);
    rd(ADDR_DATA + 12'h4);
    // Single byte lanes: each write may touch only its own half of the word.
    wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'b1, 6'h2a));
    avs_byteenable <= 4'h2;
    wr(ADDR_DATA, 16'($urandom));
    avs_byteenable <= 4'h1;
    wr(ADDR_DATA, 16'($urandom));
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 6'h2a));
    avs_byteenable <= 4'hf;
    rd(ADDR_CTRL);
    rd(ADDR_DATA);
    for (int p = 8'h19; p <= 8'h3b; p++) begin
      wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 6'(p)));
      wr(ADDR_DATA, ((p - 8'h19) % 5 == 2) ? 16'h4000 : 16'h0);
    end
    wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, 6'h1b));
    wr(ADDR_DATA, 16'h2000);
    stall = 2;
    send(3);
    repeat (3) @(posedge clk_i);
    check(in_ready_o, 1'b0);
    stall = 1;
    send(40);
    drain();
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 6'h1b));
    filt = 1;
    send(20);
    drain();
    wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, 6'h1b));
    filt = 0;
    send(20);
    drain();
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ctrl_m = 16'h8080;
    rd(ADDR_CTRL);
    stop_test();
  end
endmodule : tb_eqca_top
`default_nettype wire
